/* flash_seq_pkg.sv */
// package of command codes, register fields and timing counts for the flash sequencer
package flash_seq_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_PROGRAM    = 8'h40;
   localparam logic [7:0] CMD_PROG_VER   = 8'hC0;
   localparam logic [7:0] CMD_ERASE      = 8'h20;
   localparam logic [7:0] CMD_ERASE_VER  = 8'hA0;
   localparam logic [7:0] CMD_RESET      = 8'hFF;
   // ----------------------------------------------------------------
   // data values
   // ----------------------------------------------------------------
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;  // erased cell
   localparam logic [7:0]  PREPROG_BYTE  = 8'h00;  // preprogram value
   localparam logic [15:0] WDT_FREEZE    = 16'hFFFF; // watchdog load
   // ----------------------------------------------------------------
   // control register field positions
   // ----------------------------------------------------------------
   localparam int AREA_LSB  = 4;  // area select low bit
   localparam int AREA_MSB  = 5;  // area select high bit
   localparam int BUSY_BIT  = 1;  // busy flag position
   // ----------------------------------------------------------------
   // timing: program max 10 us, erase time scaled to cycles at 4 ns
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 4;
   localparam int PROG_TIME_NS    = 10000;
   localparam int ERASE_TIME_NS   = 9500;
   localparam int PROG_CYCLES  = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // sequencer modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_READ, MODE_PROGRAM, MODE_PROG_VER, MODE_ERASE_VER, MODE_RESET
   } mode_t;
endpackage : flash_seq_pkg

/* flash_cmd_if.sv */
// interface joining the cpu command end and the flash sequencer end
`timescale 1ns/1ns
`default_nettype none
interface flash_cmd_if #(parameter int AW = 12);
   logic          cmd_wr;    // pulse: write to command register
   logic [7:0]    cmd_data;  // command byte
   logic          ctl_wr;    // pulse: write to control register
   logic [7:0]    ctl_data;  // control byte
   logic          mem_wr;    // pulse: byte write to flash address
   logic          mem_rd;    // pulse: byte read of flash address
   logic [AW-1:0] mem_addr;  // flash byte address
   logic [7:0]    mem_wdata; // write data
   logic [7:0]    mem_rdata; // read data, valid the cycle after mem_rd
   logic          rd_valid;  // pulse: mem_rdata valid
   logic [7:0]    ctl_q;     // control register readback incl. busy
   logic          busy;      // erase/program busy flag
   // ----------------------------------------------------------------
   // modports
   // ----------------------------------------------------------------
   modport dev (input cmd_wr, cmd_data, ctl_wr, ctl_data, mem_wr, mem_rd,
                mem_addr, mem_wdata,
                output mem_rdata, rd_valid, ctl_q, busy);
   modport cpu (output cmd_wr, cmd_data, ctl_wr, ctl_data, mem_wr, mem_rd,
                mem_addr, mem_wdata,
                input mem_rdata, rd_valid, ctl_q, busy);
endinterface : flash_cmd_if
`default_nettype wire

/* flash_erase_command_sequencer.sv */
// flash command sequencer: decodes commands, runs program and erase
//
// Functional notes
// (RULE_01) two consecutive 0x20 writes erase selected area; the sweep covers only the first ERASE_CNT addresses
// (RULE_02) busy high during erase, low after
// (RULE_03) cpu preprograms 0x00 before initial erase
// (RULE_04) watchdog held at 0xFFFF while erasing
// (RULE_05) cpu verifies after erase, repeats until pass
// (RULE_06) 0xA0 enters erase verify, reads array
// (RULE_07) cpu stops verify on first non-0xFF byte
// (RULE_08) no preprogram needed on repeated erase
// (RULE_09) double 0xFF after 0x40/0x20 cancels, reset mode
// (RULE_10) reset command leaves array unchanged
// (RULE_11) 0x00 selects persistent read mode
// (RULE_12) after 0x40 next byte write programs
// (RULE_13) 0xC0 enters program verify mode
// (RULE_14) area bits 4-5 limit erase and program
// (RULE_15) double write needs no intervening command write
`timescale 1ns/1ns
`default_nettype none
module flash_erase_command_sequencer #(
   parameter int AW          = 12,                            // address bits
   parameter int ERASE_CNT   = flash_seq_pkg::ERASE_CYCLES,   // erase cycles
   parameter int PROG_CNT    = flash_seq_pkg::PROG_CYCLES     // program cycles
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   flash_cmd_if.dev          bus,
   output var  logic         wdt_hold,  // watchdog frozen
   output var  logic [15:0]  wdt_load,  // watchdog load value
   output var  logic [2:0]   mode       // current mode for observation
);
   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   localparam int DEPTH = 1 << AW;
   localparam int CW    = 16;
   logic [7:0] mem [DEPTH];             // flash array
   flash_seq_pkg::mode_t mode_r, mode_nxt;   // command mode
   logic [7:0]  last_cmd_r, last_cmd_nxt;    // previous command byte
   logic        erase_pend_r, erase_pend_nxt; // one 0x20 seen
   logic        prog_pend_r, prog_pend_nxt;   // 0x40 armed, no write yet
   logic        rst_pend_r, rst_pend_nxt;     // first 0xFF after 0x40/0x20
   logic        abortable_r, abortable_nxt;   // last op was 0x40 or 0x20
   logic        erasing_r, erasing_nxt;       // erase running
   logic        progging_r, progging_nxt;     // program running
   logic [CW-1:0] cnt_r, cnt_nxt;            // operation timer
   logic [AW-1:0] ers_idx_r, ers_idx_nxt;     // erase sweep address
   logic [AW-1:0] pa_r, pa_nxt;              // program address
   logic [7:0]  pd_r, pd_nxt;                // program data
   logic [1:0]  area_r, area_nxt;            // area select
   logic [7:0]  rdata_r;                     // read data register
   logic        rvalid_r;                    // read valid register

   // area of an address: top two address bits
   function automatic logic [1:0] area_of(input logic [AW-1:0] a);
      area_of = a[AW-1:AW-2];
   endfunction : area_of

   // ----------------------------------------------------------------
   // command decode and operation sequencing
   // ----------------------------------------------------------------
   always_comb begin
      mode_nxt       = mode_r;
      last_cmd_nxt   = last_cmd_r;
      erase_pend_nxt = erase_pend_r;
      prog_pend_nxt  = prog_pend_r;
      rst_pend_nxt   = rst_pend_r;
      abortable_nxt  = abortable_r;
      erasing_nxt    = erasing_r;
      progging_nxt   = progging_r;
      cnt_nxt        = cnt_r;
      ers_idx_nxt    = ers_idx_r;
      pa_nxt         = pa_r;
      pd_nxt         = pd_r;
      area_nxt       = area_r;
      // control write: area bits sampled only when idle
      if (bus.ctl_wr && !erasing_r && !progging_r) begin
         area_nxt = bus.ctl_data[flash_seq_pkg::AREA_MSB:
                                 flash_seq_pkg::AREA_LSB]; // RULE_14
      end
      // commands ignored while an operation runs
      if (bus.cmd_wr && !erasing_r && !progging_r) begin
         last_cmd_nxt   = bus.cmd_data;
         erase_pend_nxt = 1'b0;                       // RULE_15
         rst_pend_nxt   = 1'b0;                       // RULE_15
         // any command drops an armed program; only 0x40 re-arms
         prog_pend_nxt  = 1'b0;
         abortable_nxt  = 1'b0;
         case (bus.cmd_data)
            flash_seq_pkg::CMD_READ:
               mode_nxt = flash_seq_pkg::MODE_READ;         // RULE_11
            flash_seq_pkg::CMD_PROGRAM: begin
               mode_nxt      = flash_seq_pkg::MODE_PROGRAM; // RULE_12
               prog_pend_nxt = 1'b1;
               abortable_nxt = 1'b1;
            end
            flash_seq_pkg::CMD_PROG_VER:
               mode_nxt = flash_seq_pkg::MODE_PROG_VER;     // RULE_13
            flash_seq_pkg::CMD_ERASE_VER:
               mode_nxt = flash_seq_pkg::MODE_ERASE_VER;    // RULE_06
            flash_seq_pkg::CMD_ERASE: begin
               abortable_nxt = 1'b1;
               if (last_cmd_r == flash_seq_pkg::CMD_ERASE
                   && erase_pend_r) begin
                  erasing_nxt    = 1'b1;              // RULE_01
                  cnt_nxt        = '0;
                  ers_idx_nxt    = '0;
               end else begin
                  erase_pend_nxt = 1'b1;
               end
            end
            flash_seq_pkg::CMD_RESET: begin
               if (rst_pend_r) begin
                  // second 0xFF cancels; array untouched
                  mode_nxt     = flash_seq_pkg::MODE_RESET; // RULE_09 RULE_10
               end else if (abortable_r) begin
                  rst_pend_nxt = 1'b1;                      // RULE_09
               end
            end
            default: begin
               // unknown code keeps mode, breaks sequences
            end
         endcase
      end
      // program start: byte write after 0x40, only inside area
      if (bus.mem_wr && prog_pend_r && !bus.cmd_wr
          && !erasing_r && !progging_r) begin
         prog_pend_nxt = 1'b0;
         abortable_nxt = 1'b0;
         if (area_of(bus.mem_addr) == area_r) begin  // RULE_14
            progging_nxt = 1'b1;                       // RULE_12
            cnt_nxt      = '0;
            pa_nxt       = bus.mem_addr;
            pd_nxt       = bus.mem_wdata;
         end
      end
      // running operation timers
      if (erasing_r) begin
         if (ers_idx_r != {AW{1'b1}}) begin
            ers_idx_nxt = ers_idx_r + 1'b1;
         end
         if (cnt_r == CW'(ERASE_CNT - 1)) begin
            erasing_nxt   = 1'b0;                     // RULE_02
            abortable_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
      if (progging_r) begin
         if (cnt_r == CW'(PROG_CNT - 1)) begin
            progging_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_r       <= flash_seq_pkg::MODE_READ;
         last_cmd_r   <= flash_seq_pkg::CMD_READ;
         erase_pend_r <= 1'b0;
         prog_pend_r  <= 1'b0;
         rst_pend_r   <= 1'b0;
         abortable_r  <= 1'b0;
         erasing_r    <= 1'b0;
         progging_r   <= 1'b0;
         // timer, sweep and program latches load when an op starts
         area_r       <= 2'h0;
      end else begin
         mode_r       <= mode_nxt;
         last_cmd_r   <= last_cmd_nxt;
         erase_pend_r <= erase_pend_nxt;
         prog_pend_r  <= prog_pend_nxt;
         rst_pend_r   <= rst_pend_nxt;
         abortable_r  <= abortable_nxt;
         erasing_r    <= erasing_nxt;
         progging_r   <= progging_nxt;
         cnt_r        <= cnt_nxt;
         ers_idx_r    <= ers_idx_nxt;
         pa_r         <= pa_nxt;
         pd_r         <= pd_nxt;
         area_r       <= area_nxt;
      end
   end

   // ----------------------------------------------------------------
   // array: erase sweeps one byte a cycle; program ands bits on finish
   // no reset on the array so it survives rst_n like real flash
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst_n && erasing_r && area_of(ers_idx_r) == area_r) begin
         mem[ers_idx_r] <= flash_seq_pkg::ERASED_BYTE;       // RULE_14
      end
      if (rst_n && progging_r && cnt_r == CW'(PROG_CNT - 1)) begin
         mem[pa_r] <= mem[pa_r] & pd_r;                      // RULE_12
      end
   end

   // ----------------------------------------------------------------
   // reads return stored contents in every mode; one cycle latency
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= bus.mem_rd;
         if (bus.mem_rd) begin
            rdata_r <= mem[bus.mem_addr];   // RULE_06
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign bus.busy      = erasing_r | progging_r;             // RULE_02
   assign bus.mem_rdata = rdata_r;
   assign bus.rd_valid  = rvalid_r;
   assign bus.ctl_q     = {2'b00, area_r, 2'b00,
                           erasing_r | progging_r, 1'b0};
   assign wdt_hold      = erasing_r | progging_r;             // RULE_04
   assign wdt_load      = flash_seq_pkg::WDT_FREEZE;          // RULE_04
   assign mode          = mode_r;
endmodule : flash_erase_command_sequencer
`default_nettype wire

/* flash_cpu_erase_end.sv */
// cpu end: preprogram, erase, erase verify loop over the selected area
`timescale 1ns/1ns
`default_nettype none
module flash_cpu_erase_end #(
   parameter int AW = 12
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   flash_cmd_if.cpu         bus,
   input  wire logic        start,      // pulse: erase selected area
   input  wire logic [1:0]  area,       // area to erase
   output var  logic        done,       // pulse: area verified erased
   output var  logic [7:0]  passes      // erase attempts taken
);
   typedef enum logic [3:0] {
      S_IDLE, S_CTL, S_PCMD, S_PWR, S_PWAIT, S_PNEXT, S_E1, S_E2,
      S_EWAIT, S_VCMD, S_VRD, S_VCHK, S_DONE
   } st_t;
   st_t st_r, st_nxt;                  // cpu sequence state
   logic [AW-3:0] off_r, off_nxt;      // offset within area
   logic [7:0]    pass_r, pass_nxt;    // erase attempts
   logic          op_r, op_nxt;        // command issued, await busy drop
   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      off_nxt = off_r;
      pass_nxt = pass_r;
      op_nxt = op_r;
      case (st_r)
         S_IDLE: if (start) begin
            st_nxt = S_CTL;
            pass_nxt = 8'h00;
         end
         S_CTL:  begin st_nxt = S_PCMD; off_nxt = '0; end
         S_PCMD: st_nxt = S_PWR;          // RULE_03
         S_PWR:  begin st_nxt = S_PWAIT; op_nxt = 1'b1; end
         S_PWAIT: if (op_r) op_nxt = 1'b0;
                  else if (!bus.busy) st_nxt = S_PNEXT;
         S_PNEXT: begin
            off_nxt = off_r + 1'b1;
            st_nxt = (&off_r) ? S_E1 : S_PCMD;
         end
         S_E1:   st_nxt = S_E2;
         S_E2:   begin
            st_nxt = S_EWAIT;
            op_nxt = 1'b1;
            pass_nxt = pass_r + 1'b1;
         end
         S_EWAIT: if (op_r) op_nxt = 1'b0;
                  else if (!bus.busy) st_nxt = S_VCMD;
         S_VCMD: begin st_nxt = S_VRD; off_nxt = '0; end  // RULE_05
         S_VRD:  st_nxt = S_VCHK;
         S_VCHK: if (bus.rd_valid) begin
            if (bus.mem_rdata != flash_seq_pkg::ERASED_BYTE) begin
               st_nxt = S_E1;             // RULE_07 RULE_08
            end else if (&off_r) begin
               st_nxt = S_DONE;
            end else begin
               off_nxt = off_r + 1'b1;
               st_nxt = S_VRD;
            end
         end
         S_DONE: st_nxt = S_IDLE;
         default: st_nxt = S_IDLE;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= S_IDLE; off_r <= '0; pass_r <= 8'h00; op_r <= 1'b0;
      end else begin
         st_r <= st_nxt; off_r <= off_nxt; pass_r <= pass_nxt;
         op_r <= op_nxt;
      end
   end
   // ----------------------------------------------------------------
   // bus drive, decoded from registered state
   // ----------------------------------------------------------------
   always_comb begin
      bus.cmd_wr    = (st_r == S_PCMD) || (st_r == S_E1)
                      || (st_r == S_E2) || (st_r == S_VCMD);
      bus.cmd_data  = (st_r == S_PCMD) ? flash_seq_pkg::CMD_PROGRAM :
                      (st_r == S_VCMD) ? flash_seq_pkg::CMD_ERASE_VER :
                      flash_seq_pkg::CMD_ERASE;
      bus.ctl_wr    = (st_r == S_CTL);
      bus.ctl_data  = {2'b00, area, 4'h0};
      bus.mem_wr    = (st_r == S_PWR);
      bus.mem_rd    = (st_r == S_VRD);
      bus.mem_addr  = {area, off_r};
      bus.mem_wdata = flash_seq_pkg::PREPROG_BYTE;
   end
   assign done   = (st_r == S_DONE);
   assign passes = pass_r;
endmodule : flash_cpu_erase_end
`default_nettype wire

/* flash_seq_properties.sv */
// checker of the command sequencer as seen on the shared command bus
`timescale 1ns/1ns
`default_nettype none
module flash_seq_properties #(
   parameter int ERASE_CNT = 300,  // erase busy length
   parameter int PROG_CNT  = 300   // program busy length
) (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        cmd_wr,
   input wire logic [7:0]  cmd_data,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic        rd_valid,
   input wire logic [7:0]  ctl_q,
   input wire logic        busy,
   input wire logic        wdt_hold,
   input wire logic [15:0] wdt_load,
   input wire logic [2:0]  mode
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // busy length counter
   // ----------------------------------------------------------------
   int busy_len_r;    // cycles busy has stood high
   int busy_len_nxt;  // next count
   // counting beats a long repetition, which the tools unroll
   always_comb begin
      busy_len_nxt = busy ? busy_len_r + 1 : 0;
   end
   always_ff @(posedge core_clk) begin
      busy_len_r <= rst_n ? busy_len_nxt : 0;
   end
   // ----------------------------------------------------------------
   // sequences and properties
   // ----------------------------------------------------------------
   sequence s_cmd(logic [7:0] c);
      cmd_wr && cmd_data == c && !busy;
   endsequence
   sequence s_erase2;
      s_cmd(8'h20) ##1 s_cmd(8'h20);
   endsequence
   property p_erase_start;
      s_erase2 |=> busy;
   endproperty
   property p_busy_len;
      $fell(busy) |-> busy_len_r == ERASE_CNT || busy_len_r == PROG_CNT;
   endproperty
   property p_busy_hold;
      $rose(busy) |-> busy [*8];
   endproperty
   property p_busy_cause;
      $rose(busy) |-> ($past(cmd_wr) && $past(cmd_data) == 8'h20)
                      || $past(mem_wr);
   endproperty
   property p_wdt;
      busy |-> wdt_hold && wdt_load == 16'hFFFF;
   endproperty
   property p_busy_bit;
      ctl_q[1] == busy;
   endproperty
   property p_rd;
      mem_rd |=> rd_valid;
   endproperty
   property p_rd_only;
      rd_valid |-> $past(mem_rd);
   endproperty
   property p_ev_mode;
      s_cmd(8'hA0) |=> mode == flash_seq_pkg::MODE_ERASE_VER;
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("no erase after double erase code");
   a_busy_len: assert property (p_busy_len)
      else $error("wrong busy length");
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped early");
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy rose without a cause");
   a_wdt: assert property (p_wdt)
      else $error("watchdog not frozen while busy");
   a_busy_bit: assert property (p_busy_bit)
      else $error("busy bit wrong");
   a_rd: assert property (p_rd)
      else $error("no read data");
   a_rd_only: assert property (p_rd_only)
      else $error("stray read valid");
   a_ev_mode: assert property (p_ev_mode)
      else $error("no erase verify mode");
endmodule : flash_seq_properties
`default_nettype wire

/* test_flash_erase_command_sequencer.sv */
// self-checking bench: cpu end against sequencer, plus a directed one
`timescale 1ns/1ns
`default_nettype none
module test_flash_erase_command_sequencer;
   localparam int AW  = 8;    // small array keeps sweeps short
   localparam int CNT = 300;  // shortened erase and program time
   logic        core_clk;     // 250 MHz
   logic        rst_n;        // sync reset, active low
   logic        start;        // cpu end request
   logic [1:0]  area;         // area for the cpu end
   logic        done;         // cpu end finished
   logic [7:0]  passes;       // erase attempts taken
   logic        hold_a;       // watchdog hold, pair a
   logic        hold_b;       // watchdog hold, sequencer b
   logic [15:0] load_a;       // watchdog load, pair a
   logic [15:0] load_b;       // watchdog load, sequencer b
   logic [2:0]  mode_a;       // mode, pair a
   logic [2:0]  mode_b;       // mode, sequencer b
   int          zero_wr_a;    // preprogram writes seen on bus a
   int          erase_wr_a;   // erase code writes seen on bus a
   int          miscompares;  // mismatches
   int          tests_run;    // comparisons made
   flash_cmd_if #(.AW(AW)) bus_a ();  // cpu end to sequencer
   flash_cmd_if #(.AW(AW)) bus_b ();  // bench to second sequencer
   flash_erase_command_sequencer #(.AW(AW), .ERASE_CNT(CNT), .PROG_CNT(CNT))
      flash_erase_command_sequencer_i (.core_clk(core_clk), .rst_n(rst_n),
      .bus(bus_a.dev), .wdt_hold(hold_a), .wdt_load(load_a), .mode(mode_a));
   flash_erase_command_sequencer #(.AW(AW), .ERASE_CNT(CNT), .PROG_CNT(CNT))
      flash_erase_command_sequencer_b_i (.core_clk(core_clk), .rst_n(rst_n),
      .bus(bus_b.dev), .wdt_hold(hold_b), .wdt_load(load_b), .mode(mode_b));
   flash_cpu_erase_end #(.AW(AW)) flash_cpu_erase_end_i (.core_clk(core_clk),
      .rst_n(rst_n), .bus(bus_a.cpu), .start(start), .area(area),
      .done(done), .passes(passes));
   flash_seq_properties #(.ERASE_CNT(CNT), .PROG_CNT(CNT))
      flash_seq_properties_i (.core_clk(core_clk), .rst_n(rst_n),
      .cmd_wr(bus_a.cmd_wr), .cmd_data(bus_a.cmd_data),
      .mem_wr(bus_a.mem_wr), .mem_rd(bus_a.mem_rd),
      .rd_valid(bus_a.rd_valid), .ctl_q(bus_a.ctl_q), .busy(bus_a.busy),
      .wdt_hold(hold_a), .wdt_load(load_a), .mode(mode_a));
   // ----------------------------------------------------------------
   // clock and wire monitor of pair a
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // preprogram writes must stay inside the chosen area
   always @(posedge core_clk) begin
      if (bus_a.mem_wr === 1'b1 && bus_a.mem_wdata === 8'h00 &&
          bus_a.mem_addr[AW-1:AW-2] === area)
         zero_wr_a++;
      if (bus_a.cmd_wr === 1'b1 && bus_a.cmd_data === 8'h20)
         erase_wr_a++;
   end
   // ----------------------------------------------------------------
   // compare, bus cycles on bus b
   // ----------------------------------------------------------------
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick();
      @(posedge core_clk); #1;
   endtask : tick
   // n command writes back to back, no gap between them
   task automatic cmd(logic [7:0] c, int n);
      bus_b.cmd_wr = 1'b1;
      bus_b.cmd_data = c;
      repeat (n) @(posedge core_clk);
      #1;
      bus_b.cmd_wr = 1'b0;
      tick();
   endtask : cmd
   task automatic ctl(logic [7:0] d);
      bus_b.ctl_wr = 1'b1;
      bus_b.ctl_data = d;
      tick();
      bus_b.ctl_wr = 1'b0;
      tick();
   endtask : ctl
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus_b.mem_wr = 1'b1;
      bus_b.mem_addr = a;
      bus_b.mem_wdata = d;
      tick();
      bus_b.mem_wr = 1'b0;
      tick();
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      bus_b.mem_rd = 1'b1;
      bus_b.mem_addr = a;
      tick();
      bus_b.mem_rd = 1'b0;
      chk("rd_valid", 16'h1, 16'(bus_b.rd_valid));
      chk("read data", 16'(exp), 16'(bus_b.mem_rdata));
      tick();
   endtask : rd
   // one cycle of busy has passed when a driver task returns
   task automatic wait_busy(int exp);
      int n;
      n = 0;
      while (bus_b.busy === 1'b1 && n < 1000) begin
         tick();
         n++;
      end
      chk("busy length", exp[15:0], n[15:0]);
   endtask : wait_busy
   task automatic chk_busy(logic b);
      chk("busy", 16'(b), 16'(bus_b.busy));
   endtask : chk_busy
   task automatic chk_mode(flash_seq_pkg::mode_t m);
      chk("mode", 16'(m), 16'(mode_b));
   endtask : chk_mode
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_cpu_erase();
      int n;
      n = 0;
      area = 2'h1;
      start = 1'b1;
      tick();
      start = 1'b0;
      while (done !== 1'b1 && n < 40000) begin
         tick();
         n++;
      end
      chk("done", 16'h1, 16'(done));
      chk("passes", 16'h1, 16'(passes));
      chk("preprogram", 16'(2 ** (AW - 2)), zero_wr_a[15:0]);
      chk("erase codes", 16'h2, erase_wr_a[15:0]);
   endtask : t_cpu_erase
   task automatic t_erase();
      ctl(8'h00);
      cmd(flash_seq_pkg::CMD_ERASE, 2);
      chk_busy(1'b1);
      chk("wdt hold", 16'h1, 16'(hold_b));
      chk("wdt load", 16'hFFFF, load_b);
      wait_busy(CNT - 1);
      cmd(flash_seq_pkg::CMD_ERASE_VER, 1);
      chk_mode(flash_seq_pkg::MODE_ERASE_VER);
      rd(8'h00, 8'hFF);
      rd(8'h3F, 8'hFF);
   endtask : t_erase
   // program in area, refused outside, erase of the other area
   task automatic t_program();
      cmd(flash_seq_pkg::CMD_PROGRAM, 1);
      wr(8'h05, 8'h5A);
      wait_busy(CNT - 1);
      cmd(flash_seq_pkg::CMD_PROG_VER, 1);
      chk_mode(flash_seq_pkg::MODE_PROG_VER);
      rd(8'h05, 8'h5A);
      cmd(flash_seq_pkg::CMD_PROGRAM, 1);
      wr(8'h45, 8'h00);
      chk_busy(1'b0);
      ctl(8'h10);
      chk("area bits", 16'h10, 16'(bus_b.ctl_q & 8'h30));
      cmd(flash_seq_pkg::CMD_ERASE, 2);
      wait_busy(CNT - 1);
      rd(8'h45, 8'hFF);
      rd(8'h05, 8'h5A);
   endtask : t_program
   task automatic t_abort();
      cmd(flash_seq_pkg::CMD_ERASE, 1);
      cmd(flash_seq_pkg::CMD_RESET, 2);
      chk_busy(1'b0);
      chk_mode(flash_seq_pkg::MODE_RESET);
      ctl(8'h00);
      cmd(flash_seq_pkg::CMD_PROGRAM, 1);
      cmd(flash_seq_pkg::CMD_RESET, 2);
      chk_mode(flash_seq_pkg::MODE_RESET);
      wr(8'h05, 8'h00);
      chk_busy(1'b0);
      rd(8'h05, 8'h5A);
   endtask : t_abort
   // a command between two erase codes breaks the pair
   task automatic t_broken_pair();
      cmd(flash_seq_pkg::CMD_ERASE, 1);
      cmd(flash_seq_pkg::CMD_READ, 1);
      chk_mode(flash_seq_pkg::MODE_READ);
      cmd(flash_seq_pkg::CMD_ERASE, 1);
      chk_busy(1'b0);
      rd(8'h05, 8'h5A);
      cmd(flash_seq_pkg::CMD_RESET, 2);
   endtask : t_broken_pair
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      area = 2'h0;
      zero_wr_a = 0;
      erase_wr_a = 0;
      miscompares = 0;
      tests_run = 0;
      bus_b.cmd_wr = 1'b0;
      bus_b.cmd_data = 8'h00;
      bus_b.ctl_wr = 1'b0;
      bus_b.ctl_data = 8'h00;
      bus_b.mem_wr = 1'b0;
      bus_b.mem_rd = 1'b0;
      bus_b.mem_addr = 8'h00;
      bus_b.mem_wdata = 8'h00;
      repeat (4) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_cpu_erase();
      t_erase();
      t_program();
      t_abort();
      t_broken_pair();
      wrap_up();
   end
   initial begin
      #(4 * 90000);
      miscompares++;
      wrap_up();
   end
endmodule : test_flash_erase_command_sequencer
`default_nettype wire
